// File: rtl/tmr_cfg.svh
/*
 * constants for the dual timer/counter: register addresses, bit positions,
 * reset values and the machine-cycle prescale.
 * assumes an 8-bit special function register port and one processor clock.
 */
`ifndef TMR_CFG_SVH
`define TMR_CFG_SVH

// register addresses on the special function register port
`define TMR_ADDR_RUN_CTRL 8'h88
`define TMR_ADDR_MODE_SEL 8'h89
`define TMR_ADDR_T0_LOW 8'h8a
`define TMR_ADDR_T1_LOW 8'h8b
`define TMR_ADDR_T0_HIGH 8'h8c
`define TMR_ADDR_T1_HIGH 8'h8d

// reset values
`define TMR_RST_BYTE 8'h00

// timer_run_control bit positions
`define TMR_RUN0_BIT 4
`define TMR_OVF0_BIT 5
`define TMR_RUN1_BIT 6
`define TMR_OVF1_BIT 7

// timer_mode_select fields: timer 0 in the low nibble, timer 1 in the high one
`define TMR_T0_MODE_LSB 0
`define TMR_T0_SRC_BIT 2
`define TMR_T1_MODE_LSB 4
`define TMR_T1_SRC_BIT 6

// one machine cycle is twelve processor clock periods
`define TMR_CLKS_PER_MC 12
`define TMR_PRE_LAST 4'hb
`define TMR_PRE_ZERO 4'h0
`define TMR_PRE_ONE 4'h1

// thirteen-bit mode keeps the three top bits of the low byte at zero
`define TMR_LOW_KEEP 8'h1f
`define TMR_ALL_ONES 8'hff

`endif

// File: rtl/tmr_pkg.sv
/*
 * types shared by the dual timer/counter modules.
 * assumes nothing beyond the constants header.
 */
package tmr_pkg;

    // two mode bits per timer
    typedef enum logic [1:0] {
        TMR_MODE_13BIT,
        TMR_MODE_16BIT,
        TMR_MODE_RELOAD8,
        TMR_MODE_SPLIT
    } tmr_mode_e;

endpackage : tmr_pkg

// File: rtl/tmr_edge_det.sv
/*
 * falling-edge detector for one external count input.
 * assumes the pin is asynchronous to clk and mc_tick pulses once per
 * machine cycle; each level must stand at least one machine cycle.
 */
`timescale 1ns/1ps
`include "tmr_cfg.svh"

module tmr_edge_det (
    input wire logic clk,
    input wire logic rstn,
    input wire logic pin,
    input wire logic mc_tick,
    output logic fall
);

    logic sync1;
    logic sync2;
    logic sync3;
    logic level;
    logic sample;

    ////////////////////////////////////////////////////////////////////////////
    // three-stage synchroniser; the first stage feeds only the second
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync1 <= 1'b1;
            sync2 <= 1'b1;
            sync3 <= 1'b1;
        end else begin
            sync1 <= pin;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // a change is accepted once stages two and three agree
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            level <= 1'b1;
        end else if (sync2 == sync3) begin
            level <= sync3;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sample once per machine cycle; a 1 then 0 sample pair is an edge
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sample <= 1'b1;
            fall <= 1'b0;
        end else begin
            fall <= mc_tick & sample & ~level;
            if (mc_tick) begin
                sample <= level;
            end
        end
    end

endmodule : tmr_edge_det

// File: rtl/tmr_timers.sv
/*
 * two timer/counters with four modes each, reached through the special
 * function register port of the processor core.
 * assumes clk is the processor clock and the count inputs are asynchronous.
 */
// What this block does
// - two mode bits select one of four modes
// - 13-bit mode: low five bits plus high byte
// - reload mode: high byte holds reload value only
// - reload mode: low byte overflow reloads from high
// - timer 1 mode 3 stops and holds
// - timer 0 mode 3 splits into two 8-bit
// - timer counts once every twelve clocks
// - counter counts detected falling input edges
// - count only while own run bit is set; timer 0 split high half uses timer 1's
`timescale 1ns/1ps
`include "tmr_cfg.svh"

module tmr_timers (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic timer0_count_input,
    input wire logic timer1_count_input
);

    logic [7:0] timer_run_control;
    logic [7:0] timer_mode_select;
    logic [7:0] timer0_count_low;
    logic [7:0] timer0_count_high;
    logic [7:0] timer1_count_low;
    logic [7:0] timer1_count_high;
    logic [3:0] prescale;
    logic mc_tick;
    logic fall0;
    logic fall1;
    tmr_pkg::tmr_mode_e mode0;
    tmr_pkg::tmr_mode_e mode1;
    logic inc0;
    logic inc1;
    logic inc0_high;
    logic [17:0] next_t0;
    logic [17:0] next_t1;
    logic wr_ctrl;
    logic wr_t0_low;
    logic wr_t0_high;
    logic wr_t1_low;
    logic wr_t1_high;

    // one step of a timer: returns {high overflow, low overflow, high, low}
    function automatic logic [17:0] tmr_step(input tmr_pkg::tmr_mode_e mode, input logic [7:0] low,
                                             input logic [7:0] high, input logic inc, input logic inc_high,
                                             input logic may_split);
        logic [13:0] sum13;
        logic [16:0] sum16;
        logic [8:0] sum_low;
        logic [8:0] sum_high;
        sum13 = {1'b0, high, low[4:0]} + 14'h0001;
        sum16 = {1'b0, high, low} + 17'h00001;
        sum_low = {1'b0, low} + 9'h001;
        sum_high = {1'b0, high} + 9'h001;
        tmr_step = {2'b00, high, low};
        case (mode)
            tmr_pkg::TMR_MODE_13BIT: begin
                // upper three low-byte bits kept at zero, wraps after all ones
                tmr_step = {2'b00, high, low & `TMR_LOW_KEEP};
                if (inc) begin
                    tmr_step = {1'b0, sum13[13], sum13[12:5], 3'b000, sum13[4:0]};
                end
            end
            tmr_pkg::TMR_MODE_16BIT: begin
                if (inc) begin
                    tmr_step = {1'b0, sum16[16], sum16[15:0]};
                end
            end
            tmr_pkg::TMR_MODE_RELOAD8: begin
                // high byte never counts, it only feeds the reload
                if (inc) begin
                    tmr_step = {1'b0, sum_low[8], high, sum_low[8] ? high : sum_low[7:0]};
                end
            end
            tmr_pkg::TMR_MODE_SPLIT: begin
                // only timer 0 may split; timer 1 holds its value
                if (may_split) begin
                    tmr_step = {inc_high & sum_high[8], inc & sum_low[8],
                                inc_high ? sum_high[7:0] : high, inc ? sum_low[7:0] : low};
                end
            end
            default: tmr_step = {2'b00, high, low};
        endcase
    endfunction : tmr_step

    ////////////////////////////////////////////////////////////////////////////
    // machine-cycle prescaler
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prescale <= `TMR_PRE_ZERO;
        end else if (prescale == `TMR_PRE_LAST) begin
            prescale <= `TMR_PRE_ZERO;
        end else begin
            prescale <= prescale + `TMR_PRE_ONE;
        end
    end

    assign mc_tick = (prescale == `TMR_PRE_LAST);

    // external count inputs
    tmr_edge_det u_edge0 (
        .clk(clk),
        .rstn(rstn),
        .pin(timer0_count_input),
        .mc_tick(mc_tick),
        .fall(fall0)
    );

    tmr_edge_det u_edge1 (
        .clk(clk),
        .rstn(rstn),
        .pin(timer1_count_input),
        .mc_tick(mc_tick),
        .fall(fall1)
    );

    ////////////////////////////////////////////////////////////////////////////
    // count enables: run bit gates, source bit picks clock or input edge
    assign mode0 = tmr_pkg::tmr_mode_e'(timer_mode_select[`TMR_T0_MODE_LSB +: 2]);
    assign mode1 = tmr_pkg::tmr_mode_e'(timer_mode_select[`TMR_T1_MODE_LSB +: 2]);
    assign inc0 = timer_run_control[`TMR_RUN0_BIT] &
                  (timer_mode_select[`TMR_T0_SRC_BIT] ? fall0 : mc_tick);
    assign inc1 = timer_run_control[`TMR_RUN1_BIT] &
                  (timer_mode_select[`TMR_T1_SRC_BIT] ? fall1 : mc_tick);
    // split high half of timer 0 always times, under timer 1's run bit
    assign inc0_high = timer_run_control[`TMR_RUN1_BIT] & mc_tick;

    assign next_t0 = tmr_step(mode0, timer0_count_low, timer0_count_high, inc0, inc0_high, 1'b1);
    assign next_t1 = tmr_step(mode1, timer1_count_low, timer1_count_high, inc1, 1'b0, 1'b0);

    // register write decode
    assign wr_ctrl = sfr_wr && (sfr_addr == `TMR_ADDR_RUN_CTRL);
    assign wr_t0_low = sfr_wr && (sfr_addr == `TMR_ADDR_T0_LOW);
    assign wr_t0_high = sfr_wr && (sfr_addr == `TMR_ADDR_T0_HIGH);
    assign wr_t1_low = sfr_wr && (sfr_addr == `TMR_ADDR_T1_LOW);
    assign wr_t1_high = sfr_wr && (sfr_addr == `TMR_ADDR_T1_HIGH);

    ////////////////////////////////////////////////////////////////////////////
    // control register; an overflow in the write cycle still sets its flag
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            timer_run_control <= `TMR_RST_BYTE;
        end else begin
            if (wr_ctrl) begin
                timer_run_control <= sfr_wdata;
            end
            if (next_t0[16]) begin
                timer_run_control[`TMR_OVF0_BIT] <= 1'b1;
            end
            // timer 1 flag goes to the split high half while timer 0 splits
            if ((mode0 == tmr_pkg::TMR_MODE_SPLIT) ? next_t0[17] : next_t1[16]) begin
                timer_run_control[`TMR_OVF1_BIT] <= 1'b1;
            end
        end
    end

    // mode register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            timer_mode_select <= `TMR_RST_BYTE;
        end else if (sfr_wr && (sfr_addr == `TMR_ADDR_MODE_SEL)) begin
            timer_mode_select <= sfr_wdata;
        end
    end

    // timer 0 count; a software write wins over counting
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            timer0_count_low <= `TMR_RST_BYTE;
            timer0_count_high <= `TMR_RST_BYTE;
        end else begin
            timer0_count_low <= wr_t0_low ? sfr_wdata : next_t0[7:0];
            timer0_count_high <= wr_t0_high ? sfr_wdata : next_t0[15:8];
        end
    end

    // timer 1 count
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            timer1_count_low <= `TMR_RST_BYTE;
            timer1_count_high <= `TMR_RST_BYTE;
        end else begin
            timer1_count_low <= wr_t1_low ? sfr_wdata : next_t1[7:0];
            timer1_count_high <= wr_t1_high ? sfr_wdata : next_t1[15:8];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data, registered; unmapped addresses read zero
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sfr_rdata <= `TMR_RST_BYTE;
        end else begin
            case (sfr_addr)
                `TMR_ADDR_RUN_CTRL: sfr_rdata <= timer_run_control;
                `TMR_ADDR_MODE_SEL: sfr_rdata <= timer_mode_select;
                `TMR_ADDR_T0_LOW: sfr_rdata <= timer0_count_low;
                `TMR_ADDR_T1_LOW: sfr_rdata <= timer1_count_low;
                `TMR_ADDR_T0_HIGH: sfr_rdata <= timer0_count_high;
                `TMR_ADDR_T1_HIGH: sfr_rdata <= timer1_count_high;
                default: sfr_rdata <= `TMR_RST_BYTE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    logic no_wr0;
    logic no_wr1;
    assign no_wr0 = !wr_t0_low && !wr_t0_high;
    assign no_wr1 = !wr_t1_low && !wr_t1_high;

    tick_period_a: assert property (mc_tick |=> !mc_tick ##10 !mc_tick ##1 mc_tick)
        else $error("machine cycle tick not every twelve clocks");
    low_top_zero_a: assert property (mode0 == tmr_pkg::TMR_MODE_13BIT && no_wr0
                                     |=> timer0_count_low[7:5] == 3'h0)
        else $error("13-bit mode low byte top bits not zero");
    reload_value_a: assert property (mode1 == tmr_pkg::TMR_MODE_RELOAD8 && inc1 && no_wr1
                                     && timer1_count_low == `TMR_ALL_ONES
                                     |=> timer1_count_low == $past(timer1_count_high))
        else $error("reload mode low byte not reloaded");
    reload_high_a: assert property (mode1 == tmr_pkg::TMR_MODE_RELOAD8 && !wr_t1_high
                                    |=> $stable(timer1_count_high))
        else $error("reload mode high byte changed");
    t1_stop_a: assert property (mode1 == tmr_pkg::TMR_MODE_SPLIT && no_wr1
                                |=> $stable({timer1_count_high, timer1_count_low}))
        else $error("timer 1 counted in mode 3");
    split_high_a: assert property (mode0 == tmr_pkg::TMR_MODE_SPLIT && inc0_high && !wr_t0_high
                                   |=> timer0_count_high == 8'($past(timer0_count_high) + 8'h01))
        else $error("split high half did not advance");
    run_off_a: assert property (!timer_run_control[`TMR_RUN0_BIT] && mode0 == tmr_pkg::TMR_MODE_16BIT
                                && no_wr0 |=> $stable({timer0_count_high, timer0_count_low}))
        else $error("timer 0 counted while stopped");
    wrap16_a: assert property (mode0 == tmr_pkg::TMR_MODE_16BIT && inc0 && no_wr0
                               && {timer0_count_high, timer0_count_low} == 16'hffff
                               |=> {timer0_count_high, timer0_count_low} == 16'h0000)
        else $error("16-bit count did not wrap");
    edge_count_a: assert property (mode0 == tmr_pkg::TMR_MODE_16BIT && timer_mode_select[`TMR_T0_SRC_BIT]
                                   && timer_run_control[`TMR_RUN0_BIT] && fall0 && no_wr0
                                   |=> {timer0_count_high, timer0_count_low}
                                       == 16'($past({timer0_count_high, timer0_count_low}) + 16'h0001))
        else $error("counter did not advance on input edge");

endmodule : tmr_timers

// File: test/test_dual_timer_counter_modes.sv
/*
 * self-checking bench for the dual timer/counter: reset values, all four modes,
 * the run bits, counter operation on both count inputs.
 * assumes tmr_timers with a registered read port of one clock latency.
 */
`timescale 1ns/1ps
`include "tmr_cfg.svh"

`define CHK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin err_count++; \
    $display("[ERR] %s expected %h seen %h", what, exp, got); end end

module test_dual_timer_counter_modes;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic sfr_wr = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata;
    logic timer0_count_input = 1'b1;
    logic timer1_count_input = 1'b1;
    int err_count = 0;
    int comparisons = 0;

    ////////////////////////////////////////////////////////////////////////////
    // clock and device under test
    always #50 clk = ~clk;

    tmr_timers tmr_timers_inst (
        .clk(clk),
        .rstn(rstn),
        .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata),
        .timer0_count_input(timer0_count_input),
        .timer1_count_input(timer1_count_input)
    );

    ////////////////////////////////////////////////////////////////////////////
    // register port tasks
    // one-cycle write strobe, taken at the edge after it is raised
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_wr <= 1'b1;
        sfr_addr <= a;
        sfr_wdata <= d;
        @(posedge clk);
        sfr_wr <= 1'b0;
    endtask : wr

    // read data is registered, so look one edge after the address is shown
    task chk(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge clk);
        sfr_addr <= a;
        @(posedge clk);
        #1;
        `CHK(what, exp, sfr_rdata)
    endtask : chk

    // run bits stand for exactly n machine cycles between the two writes
    task run_for(input logic [7:0] bits, input int n);
        wr(`TMR_ADDR_RUN_CTRL, bits);
        repeat (`TMR_CLKS_PER_MC * n - 2) @(posedge clk);
        wr(`TMR_ADDR_RUN_CTRL, 8'h00);
    endtask : run_for

    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    // every register and an unmapped address read zero after reset
    task test_reset_values;
        chk(`TMR_ADDR_RUN_CTRL, `TMR_RST_BYTE, "run_control");
        chk(`TMR_ADDR_MODE_SEL, `TMR_RST_BYTE, "mode_select");
        chk(`TMR_ADDR_T0_LOW, `TMR_RST_BYTE, "t0_low");
        chk(`TMR_ADDR_T1_LOW, `TMR_RST_BYTE, "t1_low");
        chk(`TMR_ADDR_T0_HIGH, `TMR_RST_BYTE, "t0_high");
        chk(`TMR_ADDR_T1_HIGH, `TMR_RST_BYTE, "t1_high");
        chk(8'h8e, 8'h00, "unmapped");
    endtask : test_reset_values

    // full 16-bit count wraps through zero, then holds once stopped
    task test_mode_16bit;
        wr(`TMR_ADDR_MODE_SEL, 8'h01);
        wr(`TMR_ADDR_T0_LOW, 8'hfe);
        wr(`TMR_ADDR_T0_HIGH, 8'hff);
        run_for(8'h10, 3);
        chk(`TMR_ADDR_T0_LOW, 8'h01, "m1_low");
        chk(`TMR_ADDR_T0_HIGH, 8'h00, "m1_high");
        repeat (36) @(posedge clk);
        chk(`TMR_ADDR_T0_LOW, 8'h01, "m1_stopped");
    endtask : test_mode_16bit

    // 13-bit count keeps the top of the low byte clear and wraps at 0x1fff
    task test_mode_13bit;
        wr(`TMR_ADDR_MODE_SEL, 8'h00);
        wr(`TMR_ADDR_T0_LOW, 8'hff);
        wr(`TMR_ADDR_T0_HIGH, 8'hff);
        chk(`TMR_ADDR_T0_LOW, 8'h1f, "m0_forced");
        run_for(8'h10, 2);
        chk(`TMR_ADDR_T0_LOW, 8'h01, "m0_low");
        chk(`TMR_ADDR_T0_HIGH, 8'h00, "m0_high");
    endtask : test_mode_13bit

    // timer 1 reload: low byte overflows into the high byte's value
    task test_mode_reload;
        wr(`TMR_ADDR_MODE_SEL, 8'h20);
        wr(`TMR_ADDR_T1_LOW, 8'hfe);
        wr(`TMR_ADDR_T1_HIGH, 8'ha0);
        run_for(8'h40, 3);
        chk(`TMR_ADDR_T1_LOW, 8'ha1, "m2_low");
        chk(`TMR_ADDR_T1_HIGH, 8'ha0, "m2_high");
    endtask : test_mode_reload

    // timer 1 in mode 3 holds its value although its run bit is set
    task test_t1_hold;
        wr(`TMR_ADDR_MODE_SEL, 8'h30);
        wr(`TMR_ADDR_T1_LOW, 8'h10);
        run_for(8'h40, 4);
        chk(`TMR_ADDR_T1_LOW, 8'h10, "m3_t1_low");
        chk(`TMR_ADDR_T1_HIGH, 8'ha0, "m3_t1_high");
    endtask : test_t1_hold

    // timer 0 in mode 3: low half under run0, high half under run1
    task test_t0_split;
        wr(`TMR_ADDR_MODE_SEL, 8'h03);
        wr(`TMR_ADDR_T0_LOW, 8'h05);
        wr(`TMR_ADDR_T0_HIGH, 8'h07);
        run_for(8'h10, 3);
        chk(`TMR_ADDR_T0_LOW, 8'h08, "m3_low_run0");
        chk(`TMR_ADDR_T0_HIGH, 8'h07, "m3_high_run0");
        run_for(8'h40, 2);
        chk(`TMR_ADDR_T0_LOW, 8'h08, "m3_low_run1");
        chk(`TMR_ADDR_T0_HIGH, 8'h09, "m3_high_run1");
    endtask : test_t0_split

    // both timers count falling input edges, not machine cycles
    task test_counter;
        wr(`TMR_ADDR_MODE_SEL, 8'h55);
        wr(`TMR_ADDR_T0_LOW, 8'h00);
        wr(`TMR_ADDR_T1_LOW, 8'h00);
        wr(`TMR_ADDR_RUN_CTRL, 8'h50);
        // each level stands two machine cycles, well above the minimum
        repeat (3) begin
            @(posedge clk);
            timer0_count_input <= 1'b0;
            timer1_count_input <= 1'b0;
            repeat (24) @(posedge clk);
            timer0_count_input <= 1'b1;
            timer1_count_input <= 1'b1;
            repeat (24) @(posedge clk);
        end
        repeat (36) @(posedge clk);
        wr(`TMR_ADDR_RUN_CTRL, 8'h00);
        chk(`TMR_ADDR_T0_LOW, 8'h03, "cnt_t0");
        chk(`TMR_ADDR_T1_LOW, 8'h03, "cnt_t1");
        chk(`TMR_ADDR_MODE_SEL, 8'h55, "mode_rw");
    endtask : test_counter

    ////////////////////////////////////////////////////////////////////////////
    // verdict and run control
    task close_out;
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out

    // main sequence: reset held two cycles, then the scenarios
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        test_reset_values();
        test_mode_16bit();
        test_mode_13bit();
        test_mode_reload();
        test_t1_hold();
        test_t0_split();
        test_counter();
        close_out();
    end

    // watchdog, far beyond the roughly five hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        $display("[ERR] watchdog expected done seen hang");
        close_out();
    end
endmodule : test_dual_timer_counter_modes
